// file: bench/osc_select_dither_failsafe_tb.sv
// Self-checking bench for the clock select block
`timescale 1ns/1ns
`include "oscs_regs.vh"
// ********
// Bench
// ********
module osc_select_dither_failsafe_tb;
    reg clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
    reg alive = 1'h0, lock = 1'h0, wake = 1'h0, fqp = 1'h0, io_en = 1'h0;
    reg osc_on = 1'h0, pwm_on = 1'h0, err;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0, rdat, lfsr, e;
    reg [1:0] grp = 2'h0, mode = 2'h0, msel = 2'h2, qc = 2'h0;
    wire [31:0] prdata;
    wire [2:0] cur;
    wire [3:0] trim;
    wire pready, pslverr, tick, roll, system_reset, trap, rel, clkout;
    wire gpio, fb, rng, frc_pwr, posc_pwr, pll;
    integer failures = 0, cmp_count = 0, n, k, t;
    // Short power-up counts keep the run brief
    oscs_top #(.POWERUP_TIMER_4MS_CYC(10), .POWERUP_TIMER_16MS_CYC(20), .POWERUP_TIMER_64MS_CYC(30))
    i_dut (.CLK(clk), .RST(rst), .CE(1'h1), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .OSC_GROUP_SELECT(grp),
        .PRIMARY_OSC_MODE(mode), .SWITCH_MONITOR_SELECT(msel),
        .POWERUP_DELAY_SEL(2'h1), .OSC2_IO_ENABLE(io_en), .OSC_TICK(tick),
        .OSC_ALIVE(alive), .PLL_LOCK_IN(lock), .PWM_ROLLOVER(roll),
        .WAKE_FROM_SLEEP(wake), .FIRST_QUARTER_PHASE(fqp),
        .SYSTEM_RESET(system_reset), .CLOCK_FAIL_TRAP(trap), .OSC_CLOCK_RELEASE(rel),
        .CURRENT_OSC(cur), .RC_TRIM(trim), .RC_RANGE_HIGH(rng),
        .FAST_RC_POWER(frc_pwr), .PRIMARY_OSC_POWER(posc_pwr),
        .PLL_ENABLE(pll), .PLL_MULT(), .OSC2_CLKOUT(clkout),
        .OSC2_GPIO_MODE(gpio), .OSC_FEEDBACK_EN(fb), .WATCHDOG_CLK_SEL());
    oscs_pwm_model i_pwm (.clk(clk), .osc_on(osc_on), .pwm_on(pwm_on),
        .osc_tick(tick), .pwm_roll(roll));
    always #5 clk = ~clk;
    always @(posedge clk) begin
        qc <= qc + 2'h1;
        fqp <= qc == 2'h3;
    end
    task final_report;
        begin
            $display("failures %0d compares %0d", failures, cmp_count);
            if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("[ERR] %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    task guard(input ok);
        if (!ok) begin
            failures = failures + 1;
            $display("[ERR] %0t wait timed out", $time);
            final_report;
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            psel <= 1'h1;
            pwr <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            pen <= 1'h1;
            @(posedge clk);
            for (t = 0; t < 20 && pready !== 1'h1; t = t + 1) @(posedge clk);
            guard(t < 20);
            rdat = prdata;
            err = pslverr;
            psel <= 1'h0;
            pen <= 1'h0;
            @(posedge clk);
        end
    endtask
    task rd(input [11:0] a, input [31:0] m, input [31:0] x);
        begin
            apb(1'h0, a, 32'h0);
            chk(rdat & m, x);
        end
    endtask
    task do_reset(input [1:0] g, input [1:0] m, input [1:0] s);
        begin
            rst <= 1'h1;
            grp <= g;
            mode <= m;
            msel <= s;
            repeat (12) @(posedge clk);
            rst <= 1'h0;
        end
    endtask
    // Counts edges to release, noting when system reset let go
    task wait_rel;
        begin
            k = 0;
            for (n = 0; n < 1200 && rel !== 1'h1; n = n + 1) begin
                @(posedge clk);
                if (system_reset !== 1'h0) k = n + 1;
            end
            guard(n < 1200);
        end
    endtask
    task wait_roll(input integer c);
        begin
            for (t = 0; t < 400 && c > 0; t = t + 1) begin
                @(posedge clk);
                if (roll === 1'h1) c = c - 1;
            end
            guard(c == 0);
            repeat (3) @(posedge clk);
        end
    endtask
    initial begin
        do_reset(2'h2, 2'h2, 2'h0);
        chk(system_reset, 1'h1);
        for (n = 0; n < 1200 && trap !== 1'h1; n = n + 1) @(posedge clk);
        guard(n < 1200);
        repeat (3) @(posedge clk);
        chk({cur, posc_pwr}, {`OSCS_CODE_FRC, 1'h0});
        rd(`OSCS_CTRL_OFS, 32'h7009, 32'h0008);
        rd(12'h010, 32'hFFFFFFFF, 32'h0);
        chk(err, 1'h1);
        rd(`OSCS_CTRL_OFS, 32'h8, 32'h8);
        apb(1'h1, `OSCS_CTRL_OFS, 32'h0);
        rd(`OSCS_CTRL_OFS, 32'h8, 32'h0);
        alive <= 1'h1;
        osc_on <= 1'h1;
        do_reset(2'h2, 2'h2, 2'h2);
        wait_rel;
        chk(k >= 1010 && k <= 1020, 1'h1);
        chk(n >= 1024 && n <= 1100, 1'h1);
        chk(cur, `OSCS_CODE_EXT);
        wake <= 1'h1;
        @(posedge clk);
        wake <= 1'h0;
        repeat (3) @(posedge clk);
        chk(rel, 1'h0);
        wait_rel;
        chk(n >= 1015 && n <= 1100, 1'h1);
        lock <= 1'h1;
        repeat (3) @(posedge clk);
        rd(`OSCS_CTRL_OFS, 32'h20, 32'h20);
        lock <= 1'h0;
        apb(1'h1, `OSCS_CTRL_OFS, 32'h20);
        rd(`OSCS_CTRL_OFS, 32'h20, 32'h0);
        for (k = 1; k >= 0; k = k - 1) begin
            apb(1'h1, `OSCS_CTRL_OFS, k << 1);
            chk(rng, k);
        end
        apb(1'h1, `OSCS_PTRIM_OFS, 32'h5);
        apb(1'h1, `OSCS_STRIM_OFS, 32'h0FEDCBA8);
        chk(trim, 32'h5);
        apb(1'h1, `OSCS_CTRL_OFS, 32'h10);
        pwm_on <= 1'h1;
        for (k = 0; k < 8; k = k + 1) begin
            e = (k == 0) ? 32'h5 : (32'h0FEDCBA8 >> (4 * k - 4)) & 32'hF;
            chk(trim, e);
            wait_roll(8);
        end
        apb(1'h1, `OSCS_CTRL_OFS, 32'h4);
        apb(1'h0, `OSCS_STAT_OFS, 32'h0);
        lfsr = (rdat >> 1) & 32'h7FFF;
        for (k = 0; k < 3; k = k + 1) begin
            chk(trim, lfsr & 32'hF);
            wait_roll(8);
            lfsr = {17'h0, lfsr[13:0], lfsr[14] ^ lfsr[13]};
            rd(`OSCS_STAT_OFS, 32'hFFFE, lfsr << 1);
        end
        io_en <= 1'h1;
        do_reset(2'h2, 2'h0, 2'h2);
        for (n = 0; n < 1200 && system_reset !== 1'h0; n = n + 1) @(posedge clk);
        guard(n < 1200);
        k = 0;
        for (n = 0; n < 40; n = n + 1) begin
            err = clkout;
            @(posedge clk);
            if (clkout !== err) k = k + 1;
        end
        chk(k, 40);
        io_en <= 1'h0;
        repeat (3) @(posedge clk);
        chk({gpio, fb}, 2'h2);
        do_reset(2'h1, 2'h3, 2'h2);
        repeat (3) @(posedge clk);
        chk({cur, frc_pwr, pll}, {`OSCS_CODE_FRCPLL, 2'h3});
        final_report;
    end
endmodule // osc_select_dither_failsafe_tb

// file: bench/oscs_chk.sv
// Port assertions for the clock select block
`timescale 1ns/1ns
`include "oscs_regs.vh"
// ********
// Checker
// ********
module oscs_chk (
    input wire       CLK,
    input wire       RST,
    input wire [1:0] PRIMARY_OSC_MODE,
    input wire       OSC2_IO_ENABLE,
    input wire [1:0] SWITCH_MONITOR_SELECT,
    input wire       FIRST_QUARTER_PHASE,
    input wire       SYSTEM_RESET,
    input wire       CLOCK_FAIL_TRAP,
    input wire [2:0] CURRENT_OSC,
    input wire       FAST_RC_POWER,
    input wire       PRIMARY_OSC_POWER,
    input wire [5:0] PLL_MULT,
    input wire       OSC2_GPIO_MODE,
    input wire       OSC_FEEDBACK_EN,
    input wire       WATCHDOG_CLK_SEL
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    pll_fixed_a: assert property (!$past(RST) |-> PLL_MULT == 6'h20)
        else $error("pll factor is not 32");
    wdog_clk_a: assert property (WATCHDOG_CLK_SEL)
        else $error("watchdog clock moved");
    rst_phase_a: assert property ($fell(SYSTEM_RESET) |->
        $past(FIRST_QUARTER_PHASE)) else $error("reset left off phase");
    fail_rc_a: assert property ($rose(CLOCK_FAIL_TRAP) |->
        ##[0:2] (CURRENT_OSC == `OSCS_CODE_FRC && FAST_RC_POWER))
        else $error("no fallback to fast rc");
    fail_stop_a: assert property ($rose(CLOCK_FAIL_TRAP) |->
        ##[1:3] !PRIMARY_OSC_POWER) else $error("primary left powered");
    mon_off_a: assert property (SWITCH_MONITOR_SELECT[1] &&
        $past(SWITCH_MONITOR_SELECT[1]) |-> !CLOCK_FAIL_TRAP)
        else $error("trap with monitor off");
    rc_power_a: assert property (PRIMARY_OSC_MODE == 2'h3 &&
        $stable(PRIMARY_OSC_MODE) |-> FAST_RC_POWER)
        else $error("fast rc unpowered");
    io_gpio_a: assert property (!$past(RST) && $stable(OSC2_IO_ENABLE) &&
        PRIMARY_OSC_MODE == 2'h0 && !OSC2_IO_ENABLE |->
        OSC2_GPIO_MODE && !OSC_FEEDBACK_EN) else $error("osc2 not gpio");
    clkout_a: assert property (!$past(RST) && $stable(OSC2_IO_ENABLE) &&
        PRIMARY_OSC_MODE == 2'h0 && OSC2_IO_ENABLE |-> !OSC2_GPIO_MODE)
        else $error("osc2 not clock out");
endmodule // oscs_chk

bind oscs_top oscs_chk i_chk (.CLK(CLK), .RST(RST),
    .PRIMARY_OSC_MODE(PRIMARY_OSC_MODE), .OSC2_IO_ENABLE(OSC2_IO_ENABLE),
    .SWITCH_MONITOR_SELECT(SWITCH_MONITOR_SELECT),
    .FIRST_QUARTER_PHASE(FIRST_QUARTER_PHASE), .SYSTEM_RESET(SYSTEM_RESET),
    .CLOCK_FAIL_TRAP(CLOCK_FAIL_TRAP), .CURRENT_OSC(CURRENT_OSC),
    .FAST_RC_POWER(FAST_RC_POWER), .PRIMARY_OSC_POWER(PRIMARY_OSC_POWER),
    .PLL_MULT(PLL_MULT), .OSC2_GPIO_MODE(OSC2_GPIO_MODE),
    .OSC_FEEDBACK_EN(OSC_FEEDBACK_EN), .WATCHDOG_CLK_SEL(WATCHDOG_CLK_SEL));

// file: bench/oscs_pwm_model.sv
// Stand-in for the oscillator and the PWM time base
`timescale 1ns/1ns
// ********
// Model
// ********
module oscs_pwm_model (
    input  wire clk,
    input  wire osc_on,
    input  wire pwm_on,
    output reg  osc_tick,
    output reg  pwm_roll
);
    reg [3:0] per_q = 4'h0;
    initial osc_tick = 1'h0;
    initial pwm_roll = 1'h0;
    always @(posedge clk) begin
        // One tick a cycle keeps the source far above the slow limit
        osc_tick <= osc_on;
        per_q <= pwm_on ? per_q + 4'h1 : 4'h0;
        pwm_roll <= pwm_on && per_q == 4'hF;
    end
endmodule // oscs_pwm_model

// file: logic/oscs_top.v
// Clock select, trim dither and fail-safe supervision block
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "oscs_regs.vh"

// Contract
// [RULE1] 10-bit start-up timer counts 1024 cycles
// [RULE2] Start-up timer reruns on POR and wake
// [RULE3] PLL fixed at times 32
// [RULE4] Read-only lock flag follows PLL lock
// [RULE5] External mode: OSC2 outputs clock half rate
// [RULE6] External IO mode: OSC2 is GPIO, feedback off
// [RULE7] Fast RC powered unless ext/crystal, or failover
// [RULE8] Range bit picks low or high RC
// [RULE9] Trim from primary or sequence per enable
// [RULE10] Rollover bits 5:3 select among eight trims
// [RULE11] Rollover counter counts PWM period rollovers
// [RULE12] Dither: 15-bit LFSR low nibble trims
// [RULE13] LFSR steps when rollover bit 3 toggles
// [RULE14] Failure: trap, load RC code, flag, clear request
// [RULE15] Powerup timeout before start: trap, RC, stop osc
// [RULE16] Switch only between primary and RC groups
// [RULE17] Monitor select 1x disables switching and monitor
// [RULE18] Switch disabled: config selects, current reflects
// [RULE19] Watchdog clock unaffected by failure
// [RULE20] Software avoids clocks below 100 kHz
// [RULE21] Reset release waits POR plus powerup delay
// [RULE22] Reset releases on first quarter phase edge
// [RULE23] Fail flag sticky until software clears
module oscs_top #(
    parameter POWERUP_TIMER_4MS_CYC  = 400000,
    parameter POWERUP_TIMER_16MS_CYC = 1600000,
    parameter POWERUP_TIMER_64MS_CYC = 6400000
) (
    input  wire        CLK,
    input  wire        RST,
    input  wire        CE,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR,
    input  wire [1:0]  OSC_GROUP_SELECT,
    input  wire [1:0]  PRIMARY_OSC_MODE,
    input  wire [1:0]  SWITCH_MONITOR_SELECT,
    input  wire [1:0]  POWERUP_DELAY_SEL,
    input  wire        OSC2_IO_ENABLE,
    input  wire        OSC_TICK,
    input  wire        OSC_ALIVE,
    input  wire        PLL_LOCK_IN,
    input  wire        PWM_ROLLOVER,
    input  wire        WAKE_FROM_SLEEP,
    input  wire        FIRST_QUARTER_PHASE,
    output reg         SYSTEM_RESET,
    output reg         CLOCK_FAIL_TRAP,
    output reg         OSC_CLOCK_RELEASE,
    output reg  [2:0]  CURRENT_OSC,
    output reg  [3:0]  RC_TRIM,
    output reg         RC_RANGE_HIGH,
    output reg         FAST_RC_POWER,
    output reg         PRIMARY_OSC_POWER,
    output reg         PLL_ENABLE,
    output reg  [5:0]  PLL_MULT,
    output reg         OSC2_CLKOUT,
    output reg         OSC2_GPIO_MODE,
    output reg         OSC_FEEDBACK_EN,
    output reg         WATCHDOG_CLK_SEL
);
    // ****************************************
    // Timing constants
    // ****************************************
    localparam integer POR_CYC =
        (`OSCS_POR_NS + `OSCS_CLK_NS - 1) / `OSCS_CLK_NS;
    localparam [3:0] POR_ST = 4'h0;

    // ****************************************
    // State
    // ****************************************
    reg  [14:0] ctrl_q;
    reg  [3:0]  ptrim_q;
    reg  [27:0] strim_q;
    reg  [9:0]  ost_cnt_q;
    reg         ost_done_q;
    reg  [5:0]  roll_q;
    reg         roll3_prev_q;
    reg  [14:0] lfsr_q;
    reg  [22:0] por_cnt_q;
    reg         powerup_timer_done_q;
    reg         osc_stop_q;
    reg         cur_init_q;
    reg  [22:0] powerup_timer_target;
    reg  [3:0]  trim_d;
    reg  [2:0]  cur_d;
    reg  [31:0] rdata_d;
    reg         slot_ok;
    wire [3:0]  slot [0:7];
    wire        sw_en   = ~SWITCH_MONITOR_SELECT[1];             // [RULE17]
    wire        mon_en  = (SWITCH_MONITOR_SELECT == 2'h0);       // [RULE17]
    wire        cfg_frc = (OSC_GROUP_SELECT[1] == 1'b0);
    wire        cfg_ext = (PRIMARY_OSC_MODE == 2'h0);
    wire        cfg_hs  = (PRIMARY_OSC_MODE == 2'h2);
    wire [2:0]  cfg_code;
    wire        wr   = PSEL & PENABLE & PWRITE;
    wire        rd_ok;
    wire        fail;
    wire        on_rc;
    wire [2:0]  new_sel = ctrl_q[`OSCS_NEW_HI:`OSCS_NEW_LO];

    assign cfg_code = cfg_frc ? (OSC_GROUP_SELECT[0] ? `OSCS_CODE_FRCPLL
                                                     : `OSCS_CODE_FRC)
                              : {1'b0, 1'b1, OSC_GROUP_SELECT[0]};
    assign on_rc = (cur_d == `OSCS_CODE_FRC) | (cur_d == `OSCS_CODE_FRCPLL);
    assign rd_ok = (PADDR == `OSCS_CTRL_OFS) | (PADDR == `OSCS_PTRIM_OFS) |
                   (PADDR == `OSCS_STRIM_OFS) | (PADDR == `OSCS_STAT_OFS);
    // Failure seen only while monitor enabled and running on primary
    assign fail = mon_en & ~on_rc & powerup_timer_done_q &
                  (~OSC_ALIVE | (cfg_hs & ~ost_done_q));          // [RULE15]

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_slot
            if (gi == 0) begin : g_p
                assign slot[gi] = ptrim_q;
            end else begin : g_s
                assign slot[gi] = strim_q[gi*4-1 -: 4];
            end
        end
    endgenerate

    // ****************************************
    // Combinational selection
    // ****************************************
    always @* begin
        if (ctrl_q[`OSCS_DITH_BIT]) begin
            trim_d = lfsr_q[3:0];                                // [RULE12]
        end else if (ctrl_q[`OSCS_SEQEN_BIT]) begin
            trim_d = slot[roll_q[5:3]];                          // [RULE9] [RULE10]
        end else begin
            trim_d = ptrim_q;                                    // [RULE9]
        end
        if (sw_en) begin
            cur_d = ctrl_q[`OSCS_CUR_HI:`OSCS_CUR_LO];
        end else begin
            cur_d = cfg_code;                                    // [RULE18]
        end
        // Group switch: new selection must be the other group
        slot_ok = (new_sel == `OSCS_CODE_FRC) ? ~on_rc : on_rc;  // [RULE16]
        case (POWERUP_TIMER_SEL_IDX(POWERUP_DELAY_SEL))
            2'h0:    powerup_timer_target = POR_CYC[22:0];
            2'h1:    powerup_timer_target = POR_CYC[22:0] + POWERUP_TIMER_4MS_CYC[22:0];
            2'h2:    powerup_timer_target = POR_CYC[22:0] + POWERUP_TIMER_16MS_CYC[22:0];
            default: powerup_timer_target = POR_CYC[22:0] + POWERUP_TIMER_64MS_CYC[22:0];
        endcase                                                  // [RULE21]
        case (PADDR)
            `OSCS_CTRL_OFS:  rdata_d = {17'h0, ctrl_q[14:6],
                                        PLL_LOCK_IN, ctrl_q[4:0]}; // [RULE4]
            `OSCS_PTRIM_OFS: rdata_d = {28'h0, ptrim_q};
            `OSCS_STRIM_OFS: rdata_d = {4'h0, strim_q};
            `OSCS_STAT_OFS:  rdata_d = {16'h0, lfsr_q[14:0], ost_done_q};
            default:         rdata_d = 32'h0;
        endcase
    end

    function [1:0] POWERUP_TIMER_SEL_IDX;
        input [1:0] s;
        begin
            POWERUP_TIMER_SEL_IDX = s;
        end
    endfunction

    // ****************************************
    // Clocked state
    // ****************************************
    always @(posedge CLK) begin
        if (RST) begin
            ctrl_q       <= 15'h0;
            ptrim_q      <= 4'h0;
            strim_q      <= 28'h0;
            ost_cnt_q    <= 10'h0;
            ost_done_q   <= 1'b0;
            roll_q       <= 6'h0;
            roll3_prev_q <= 1'b0;
            lfsr_q       <= `OSCS_LFSR_SEED;
            por_cnt_q    <= 23'h0;
            powerup_timer_done_q  <= 1'b0;
            osc_stop_q   <= 1'b0;
            cur_init_q   <= 1'b0;
            PRDATA       <= 32'h0;
            PREADY       <= 1'b0;
            PSLVERR      <= 1'b0;
            SYSTEM_RESET <= 1'b1;
            CLOCK_FAIL_TRAP   <= 1'b0;
            OSC_CLOCK_RELEASE <= 1'b0;
            CURRENT_OSC  <= 3'h0;
            RC_TRIM      <= 4'h0;
            RC_RANGE_HIGH <= 1'b0;
            FAST_RC_POWER <= 1'b1;
            PRIMARY_OSC_POWER <= 1'b0;
            PLL_ENABLE   <= 1'b0;
            PLL_MULT     <= 6'h0;
            OSC2_CLKOUT  <= 1'b0;
            OSC2_GPIO_MODE <= 1'b0;
            OSC_FEEDBACK_EN <= 1'b0;
            WATCHDOG_CLK_SEL <= 1'b1;
        end else if (CE) begin
            // One wait state: answer in the second access cycle after setup
            PREADY  <= PSEL & PENABLE & ~PREADY;
            PSLVERR <= PSEL & PENABLE & ~PREADY & ~rd_ok;
            if (PSEL & PENABLE & ~PREADY) begin
                PRDATA <= PWRITE ? 32'h0 : rdata_d;
            end
            // Start-up timer restarts on wake
            if (WAKE_FROM_SLEEP) begin
                ost_cnt_q  <= 10'h0;
                ost_done_q <= 1'b0;                              // [RULE2]
            end else if (OSC_TICK & ~ost_done_q) begin
                ost_cnt_q <= ost_cnt_q + 10'h1;                  // [RULE1]
                if (ost_cnt_q == 10'h3FF) begin
                    ost_done_q <= 1'b1;                          // [RULE1]
                end
            end
            OSC_CLOCK_RELEASE <= ~cfg_hs | ost_done_q;           // [RULE1]
            if (PWM_ROLLOVER) begin
                roll_q <= roll_q + 6'h1;                         // [RULE11]
            end
            roll3_prev_q <= roll_q[3];
            if (roll_q[3] != roll3_prev_q) begin
                lfsr_q <= {lfsr_q[13:0], lfsr_q[14] ^ lfsr_q[13]}; // [RULE13]
            end
            // Power-on delay, release aligned to first quarter phase
            if (!powerup_timer_done_q) begin
                if (por_cnt_q >= powerup_timer_target) begin
                    if (FIRST_QUARTER_PHASE) begin
                        powerup_timer_done_q  <= 1'b1;
                        SYSTEM_RESET <= 1'b0;                    // [RULE22]
                    end
                end else begin
                    por_cnt_q <= por_cnt_q + 23'h1;              // [RULE21]
                end
            end
            // Software writes
            if (wr & ~PREADY & (PADDR == `OSCS_CTRL_OFS)) begin
                ctrl_q[`OSCS_NEW_HI:`OSCS_NEW_LO] <= PWDATA[10:8];
                ctrl_q[`OSCS_SEQEN_BIT] <= PWDATA[4];
                ctrl_q[`OSCS_DITH_BIT]  <= PWDATA[2];
                ctrl_q[`OSCS_RANGE_BIT] <= PWDATA[1];
                ctrl_q[`OSCS_SWREQ_BIT] <= PWDATA[0] & sw_en;
                if (PWDATA[3] == 1'b0) begin
                    ctrl_q[`OSCS_CF_BIT] <= 1'b0;                // [RULE23]
                end
            end
            if (wr & ~PREADY & (PADDR == `OSCS_PTRIM_OFS)) begin
                ptrim_q <= PWDATA[3:0];
            end
            if (wr & ~PREADY & (PADDR == `OSCS_STRIM_OFS)) begin
                strim_q <= PWDATA[27:0];
            end
            // Reset leaves the fast RC code current; the first cycle loads the configured
            // source, and the monitor watches the primary once the power-up delay is done
            if (!cur_init_q) begin
                ctrl_q[`OSCS_CUR_HI:`OSCS_CUR_LO] <= cfg_code;   // [RULE16]
                cur_init_q <= 1'b1;
            end
            if (!sw_en) begin
                ctrl_q[`OSCS_CUR_HI:`OSCS_CUR_LO] <= cfg_code;   // [RULE18]
            end else if (ctrl_q[`OSCS_SWREQ_BIT] & ~fail) begin
                if (slot_ok) begin
                    // Primary group always takes config choice
                    ctrl_q[`OSCS_CUR_HI:`OSCS_CUR_LO] <=
                        (new_sel == `OSCS_CODE_FRC) ? `OSCS_CODE_FRC
                                                    : cfg_code;  // [RULE16]
                    osc_stop_q <= 1'b0;
                end
                ctrl_q[`OSCS_SWREQ_BIT] <= 1'b0;
            end
            // Failure has priority over a clear in the same cycle
            if (fail) begin
                ctrl_q[`OSCS_CUR_HI:`OSCS_CUR_LO] <= `OSCS_CODE_FRC; // [RULE14]
                ctrl_q[`OSCS_CF_BIT]    <= 1'b1;                 // [RULE14] [RULE23]
                ctrl_q[`OSCS_SWREQ_BIT] <= 1'b0;                 // [RULE14]
                osc_stop_q <= 1'b1;                              // [RULE15]
            end
            CLOCK_FAIL_TRAP <= fail;                             // [RULE14]
            CURRENT_OSC     <= fail ? `OSCS_CODE_FRC : cur_d;
            RC_TRIM         <= trim_d;
            RC_RANGE_HIGH   <= ctrl_q[`OSCS_RANGE_BIT];          // [RULE8]
            FAST_RC_POWER   <= on_rc | fail | osc_stop_q |
                               ~(cfg_ext | cfg_hs);              // [RULE7]
            PRIMARY_OSC_POWER <= ~on_rc & ~fail & ~osc_stop_q;   // [RULE15]
            PLL_ENABLE      <= cur_d[0];
            PLL_MULT        <= `OSCS_PLL_MULT;                   // [RULE3]
            // Toggle per oscillator tick gives half the oscillator rate
            OSC2_CLKOUT     <= (cfg_ext & OSC2_IO_ENABLE) ?
                               (OSC2_CLKOUT ^ OSC_TICK) : 1'b0;  // [RULE5]
            OSC2_GPIO_MODE  <= cfg_ext & ~OSC2_IO_ENABLE;        // [RULE6]
            OSC_FEEDBACK_EN <= cfg_hs;                           // [RULE6]
            WATCHDOG_CLK_SEL <= 1'b1;                            // [RULE19]
        end
    end
    // Lock flag is read live from the PLL                       [RULE4]
endmodule // oscs_top

// file: shared/oscs_regs.vh
// Register offsets, field positions, reset values and timing counts
`ifndef OSCS_REGS_VH
`define OSCS_REGS_VH
// ****************************************
// Register byte offsets
// ****************************************
`define OSCS_CTRL_OFS      12'h000
`define OSCS_PTRIM_OFS     12'h004
`define OSCS_STRIM_OFS     12'h008
`define OSCS_STAT_OFS      12'h00C
// ****************************************
// Control register fields
// ****************************************
`define OSCS_CUR_HI        14
`define OSCS_CUR_LO        12
`define OSCS_NEW_HI        10
`define OSCS_NEW_LO        8
`define OSCS_LOCK_BIT      5
`define OSCS_SEQEN_BIT     4
`define OSCS_CF_BIT        3
`define OSCS_DITH_BIT      2
`define OSCS_RANGE_BIT     1
`define OSCS_SWREQ_BIT     0
// ****************************************
// Oscillator codes and reset values
// ****************************************
`define OSCS_CODE_FRC      3'h0
`define OSCS_CODE_FRCPLL   3'h1
`define OSCS_CODE_EXT      3'h2
`define OSCS_CODE_PLL      3'h3
`define OSCS_LFSR_SEED     15'h0001
// ****************************************
// Timing
// ****************************************
`define OSCS_OST_CYCLES    1024
`define OSCS_PLL_MULT      6'h20
`define OSCS_POR_NS        10000
`define OSCS_CLK_NS        10
`define OSCS_MS_NS         1000000
`endif
